//--- include/pfsb_pkg.sv
// Package of offsets, field positions and reset values of the status bank
package pfsb_pkg;

    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int BYTE_WIDTH = 8;

    // Register byte addresses on the bus
    localparam logic [7:0] OFF_SAFETY_ALERT_THIRD = 8'h00;
    localparam logic [7:0] OFF_SAFETY_FAULT_THIRD = 8'h04;
    localparam logic [7:0] OFF_PERMANENT_ALERT_FIRST = 8'h08;
    localparam logic [7:0] OFF_PERMANENT_FAULT_FIRST = 8'h0C;
    localparam logic [7:0] OFF_PERMANENT_ALERT_SECOND = 8'h10;
    localparam logic [7:0] OFF_PERMANENT_FAULT_SECOND = 8'h14;
    localparam logic [7:0] OFF_SAFETY_ENABLE = 8'h18;
    localparam logic [7:0] OFF_PERMANENT_ENABLE_FIRST = 8'h1C;
    localparam logic [7:0] OFF_PERMANENT_ENABLE_SECOND = 8'h20;

    // Safety third bytes
    localparam int BIT_DISCHARGE_OVERCURRENT_TIER3 = 7;
    localparam int BIT_DISCHARGE_SHORT_LATCH = 6;
    localparam int BIT_DISCHARGE_OVERCURRENT_LATCH = 5;
    localparam int BIT_CELL_OVERVOLTAGE_LATCH = 4;
    localparam int BIT_PRECHARGE_TIMEOUT_SUSPEND = 3;
    localparam int BIT_PRECHARGE_TIMEOUT_FAULT = 2;
    localparam int BIT_HOST_WATCHDOG_FAULT = 1;

    // Permanent-fail first bytes
    localparam int BIT_COPPER_DEPOSITION_FAIL = 7;
    localparam int BIT_SAFETY_FET_OVERTEMP_FAIL = 6;
    localparam int BIT_SAFETY_OVERTEMP_FAIL = 4;
    localparam int BIT_SAFETY_DISCHARGE_OVERCURRENT_FAIL = 3;
    localparam int BIT_SAFETY_CHARGE_OVERCURRENT_FAIL = 2;
    localparam int BIT_SAFETY_CELL_OVERVOLTAGE_FAIL = 1;
    localparam int BIT_SAFETY_CELL_UNDERVOLTAGE_FAIL = 0;

    // Permanent-fail second bytes
    localparam int BIT_DISCHARGE_SHORT_LATCH_FAIL = 7;
    localparam int BIT_IMBALANCE_ACTIVE_FAIL = 4;
    localparam int BIT_IMBALANCE_REST_FAIL = 3;
    localparam int BIT_SECOND_LEVEL_PROTECTOR_FAIL = 2;
    localparam int BIT_DISCHARGE_SWITCH_FAIL = 1;
    localparam int BIT_CHARGE_SWITCH_FAIL = 0;

    // Reserved positions, read as zero
    localparam logic [7:0] RSVD_SAFETY_ALERT_THIRD = 8'h07;
    localparam logic [7:0] RSVD_SAFETY_FAULT_THIRD = 8'h09;
    localparam logic [7:0] RSVD_PERMANENT_FIRST = 8'h20;
    localparam logic [7:0] RSVD_PERMANENT_SECOND = 8'h60;

    // Enable registers: implemented bits and reset values
    localparam logic [7:0] MASK_SAFETY_ENABLE = 8'hF6;
    localparam logic [7:0] RESET_SAFETY_ENABLE = 8'hF6;
    localparam logic [7:0] RESET_PERMANENT_ENABLE_FIRST = 8'hDF;
    localparam logic [7:0] RESET_PERMANENT_ENABLE_SECOND = 8'h9F;

    localparam logic [7:0] RESET_FLAGS = 8'h00;
    localparam logic [31:0] RESET_DATA = 32'h00000000;

endpackage

//--- include/pfsb_reg_if.sv
// Internal register access path between bus slave and register bank
`timescale 1ns/1ns
interface pfsb_reg_if;
    logic wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport bus (
        output wr_stb,
        output addr,
        output wdata,
        input rdata
    );

    modport regs (
        input wr_stb,
        input addr,
        input wdata,
        output rdata
    );
endinterface

//--- tb/pfsb_top_monitor.sv
// Concurrent checks on the status bank's bus port, with covers on the summary ports
`timescale 1ns/1ns
module pfsb_top_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pfsb_pkg::ADDR_WIDTH-1:0] adr_i,
    input wire logic precharge_timeout_suspend_i,
    input wire logic ack_o,
    input wire logic [pfsb_pkg::DATA_WIDTH-1:0] dat_o,
    input wire logic any_alert_o,
    input wire logic any_fault_o
);
    logic [7:0] req_adr;
    logic req_rd;
    logic rd0;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Remember the request that the current answer belongs to
    always_ff @(posedge clk_i) begin
        req_adr <= adr_i;
        req_rd <= cyc_i & stb_i & ~we_i & ~ack_o;
    end
    assign rd0 = ack_o && req_rd && req_adr == 8'h00;

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered on the next edge");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_HIGH_ZERO: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_WRITE_ZERO: assert property (ack_o && !req_rd |-> dat_o == 32'h0)
        else $error("write answer carries data");
    AST_RSVD_ALERT3: assert property (rd0 |-> dat_o[2:0] == 3'h0)
        else $error("reserved alert bits set");
    AST_RSVD_FAULT3: assert property (ack_o && req_rd && req_adr == 8'h04
        |-> !dat_o[3] && !dat_o[0]) else $error("reserved fault bits set");
    AST_RSVD_PF1: assert property (ack_o && req_rd
        && req_adr inside {8'h08, 8'h0C} |-> !dat_o[5])
        else $error("reserved first byte bit set");
    AST_RSVD_PF2: assert property (ack_o && req_rd
        && req_adr inside {8'h10, 8'h14} |-> dat_o[6:5] == 2'h0)
        else $error("reserved second byte bits set");
    // Input seen two edges before the answer is what the byte captured
    AST_SUSPEND: assert property (rd0
        |-> dat_o[3] == $past(precharge_timeout_suspend_i, 2))
        else $error("suspend bit does not follow its input");

    cover property (ack_o && req_rd);
    cover property (ack_o && !req_rd);
    cover property (any_alert_o);
    cover property (any_fault_o);
endmodule

bind pfsb_top pfsb_top_monitor i_pfsb_top_monitor (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .precharge_timeout_suspend_i, .ack_o, .dat_o,
    .any_alert_o, .any_fault_o);

//--- tb/pfsb_top_tb.sv
// Self-checking bench for the protection status bank
`timescale 1ns/1ns
module pfsb_top_tb;
    import pfsb_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, any_alert, any_fault;
    logic [3:0] sel;
    logic [7:0] adr, v, e;
    logic [31:0] dat, dat_o, q;
    logic [7:0] s [6];
    logic [7:0] mask [6];
    int num_errors, total_checks;

    pfsb_top i_pfsb_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .ack_o(ack), .dat_o(dat_o), .any_alert_o(any_alert),
        .any_fault_o(any_fault),
        .discharge_overcurrent_tier3_alert_i(s[0][7]),
        .discharge_short_latch_alert_i(s[0][6]),
        .discharge_overcurrent_latch_alert_i(s[0][5]),
        .cell_overvoltage_latch_alert_i(s[0][4]),
        .precharge_timeout_suspend_i(s[0][3]),
        .discharge_overcurrent_tier3_fault_i(s[1][7]),
        .discharge_short_latch_fault_i(s[1][6]),
        .discharge_overcurrent_latch_fault_i(s[1][5]),
        .cell_overvoltage_latch_fault_i(s[1][4]),
        .precharge_timeout_fault_i(s[1][2]),
        .host_watchdog_fault_i(s[1][1]),
        .copper_deposition_fail_alert_i(s[2][7]),
        .safety_fet_overtemp_fail_alert_i(s[2][6]),
        .safety_overtemp_fail_alert_i(s[2][4]),
        .safety_discharge_overcurrent_fail_alert_i(s[2][3]),
        .safety_charge_overcurrent_fail_alert_i(s[2][2]),
        .safety_cell_overvoltage_fail_alert_i(s[2][1]),
        .safety_cell_undervoltage_fail_alert_i(s[2][0]),
        .copper_deposition_fail_fault_i(s[3][7]),
        .safety_fet_overtemp_fail_fault_i(s[3][6]),
        .safety_overtemp_fail_fault_i(s[3][4]),
        .safety_discharge_overcurrent_fail_fault_i(s[3][3]),
        .safety_charge_overcurrent_fail_fault_i(s[3][2]),
        .safety_cell_overvoltage_fail_fault_i(s[3][1]),
        .safety_cell_undervoltage_fail_fault_i(s[3][0]),
        .discharge_short_latch_fail_alert_i(s[4][7]),
        .imbalance_active_fail_alert_i(s[4][4]),
        .imbalance_rest_fail_alert_i(s[4][3]),
        .second_level_protector_fail_alert_i(s[4][2]),
        .discharge_switch_fail_alert_i(s[4][1]),
        .charge_switch_fail_alert_i(s[4][0]),
        .discharge_short_latch_fail_fault_i(s[5][7]),
        .imbalance_active_fail_fault_i(s[5][4]),
        .imbalance_rest_fail_fault_i(s[5][3]),
        .second_level_protector_fail_fault_i(s[5][2]),
        .discharge_switch_fail_fault_i(s[5][1]),
        .charge_switch_fail_fault_i(s[5][0]));

    task results;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] x);
        total_checks++;
        if (got !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, x, got);
        end
    endtask

    // One classic Wishbone cycle; waits for ack, answer lands in q
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100)
            num_errors++;
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 32'h0);
        chk(nm, q, x);
    endtask

    task drive_all(input int r, input logic [7:0] val);
        @(posedge clk_i);
        for (int k = 0; k < 6; k++)
            s[k] <= (k == r || r > 5) ? val : 8'h00;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        results();
    end

    initial begin
        {num_errors, total_checks} = '0;
        {rst_i, cyc, stb, we, sel, adr, dat} = {1'b1, 47'h0};
        foreach (s[k]) s[k] = 8'h00;
        mask = '{8'hF8, 8'hF6, 8'hDF, 8'hDF, 8'h9F, 8'h9F};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("enable_reset", OFF_SAFETY_ENABLE, 32'hF6);
        // Walk a single one and then all ones through every byte
        for (int r = 0; r < 6; r++) begin
            for (int b = 0; b < 9; b++) begin
                v = (b == 8) ? 8'hFF : 8'h01 << b;
                e = v & mask[r];
                drive_all(r, v);
                rd("flags", 8'(r * 4), {24'h0, e});
                chk("summary", {31'h0, r[0] ? any_fault : any_alert},
                    {31'h0, |(e & (r == 0 ? 8'hF7 : 8'hFF))});
            end
        end
        wb(1'b1, OFF_SAFETY_ENABLE, 32'h0);
        wb(1'b1, OFF_PERMANENT_ENABLE_FIRST, 32'h0);
        drive_all(6, 8'hFF);
        wb(1'b1, OFF_SAFETY_ALERT_THIRD, 32'hFF);
        rd("alert3_off", OFF_SAFETY_ALERT_THIRD, 32'h08);
        rd("fault3_off", OFF_SAFETY_FAULT_THIRD, 32'h00);
        rd("pf1_off", OFF_PERMANENT_ALERT_FIRST, 32'h00);
        rd("pf2_on", OFF_PERMANENT_FAULT_SECOND, 32'h9F);
        rd("unmapped", 8'h3C, 32'h00);
        // Reset in mid-run brings the cleared enable back to its reset value
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("pf_en_reset", OFF_PERMANENT_ENABLE_FIRST, 32'hDF);
        wb(1'b1, OFF_SAFETY_ENABLE, 32'hFFFFFFFF);
        rd("enable_all", OFF_SAFETY_ENABLE, 32'hF6);
        results();
    end
endmodule

//--- verilog/pfsb_flag_byte.sv
// One status byte: flag set where enabled and triggered, reserved bits zero
`timescale 1ns/1ns
module pfsb_flag_byte #(
    parameter logic [7:0] RESERVED_MASK = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] cond_i,
    input wire logic [7:0] en_i,
    output logic [7:0] flags_o
);
    import pfsb_pkg::*;

    typedef struct packed {
        logic [7:0] flags;
    } pfsb_byte_state_type;

    pfsb_byte_state_type state;
    pfsb_byte_state_type next_state;

    always_comb begin
        next_state = state;
        // Level follows the condition: 1 while triggered, 0 otherwise
        next_state.flags = cond_i & en_i & ~RESERVED_MASK; // (R1) (R11) (R12) (R13)
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '{flags: RESET_FLAGS};
        end else begin
            state <= next_state;
        end
    end

    assign flags_o = state.flags;
endmodule

//--- verilog/pfsb_top.sv
// Protection alert and fault status bank with Wishbone register access
// Notes on behaviour
// (R1) Safety alert only when enabled and detected; bit 3 (suspend) is shown whatever the enables say
// (R2) Alert third byte bit 7: tier-3 overcurrent
// (R3) Bits 6,5,4: short, overcurrent, overvoltage latches
// (R4) Bit 3 follows precharge timeout suspension
// (R5) Fault third byte: 7,6,5,4,2,1 confirmed faults
// (R6) Permanent alerts per enabled check, separate faults
// (R7) First bytes: copper 7, FET temp 6, temp 4
// (R8) First bytes: discharge 3, charge 2, OV 1, UV 0
// (R9) Second bytes: short latch 7, imbalance 4, 3
// (R10) Second bytes: protector 2, discharge 1, charge 0
// (R11) Alert flag reads 1 triggered, 0 not
// (R12) Fault flag reads 1 triggered, 0 otherwise
// (R13) Reserved bits always read zero
`timescale 1ns/1ns
module pfsb_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pfsb_pkg::ADDR_WIDTH-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [pfsb_pkg::DATA_WIDTH-1:0] dat_i,
    output logic ack_o,
    output logic [pfsb_pkg::DATA_WIDTH-1:0] dat_o,
    input wire logic discharge_overcurrent_tier3_alert_i,
    input wire logic discharge_short_latch_alert_i,
    input wire logic discharge_overcurrent_latch_alert_i,
    input wire logic cell_overvoltage_latch_alert_i,
    input wire logic precharge_timeout_suspend_i,
    input wire logic discharge_overcurrent_tier3_fault_i,
    input wire logic discharge_short_latch_fault_i,
    input wire logic discharge_overcurrent_latch_fault_i,
    input wire logic cell_overvoltage_latch_fault_i,
    input wire logic precharge_timeout_fault_i,
    input wire logic host_watchdog_fault_i,
    input wire logic copper_deposition_fail_alert_i,
    input wire logic safety_fet_overtemp_fail_alert_i,
    input wire logic safety_overtemp_fail_alert_i,
    input wire logic safety_discharge_overcurrent_fail_alert_i,
    input wire logic safety_charge_overcurrent_fail_alert_i,
    input wire logic safety_cell_overvoltage_fail_alert_i,
    input wire logic safety_cell_undervoltage_fail_alert_i,
    input wire logic copper_deposition_fail_fault_i,
    input wire logic safety_fet_overtemp_fail_fault_i,
    input wire logic safety_overtemp_fail_fault_i,
    input wire logic safety_discharge_overcurrent_fail_fault_i,
    input wire logic safety_charge_overcurrent_fail_fault_i,
    input wire logic safety_cell_overvoltage_fail_fault_i,
    input wire logic safety_cell_undervoltage_fail_fault_i,
    input wire logic discharge_short_latch_fail_alert_i,
    input wire logic imbalance_active_fail_alert_i,
    input wire logic imbalance_rest_fail_alert_i,
    input wire logic second_level_protector_fail_alert_i,
    input wire logic discharge_switch_fail_alert_i,
    input wire logic charge_switch_fail_alert_i,
    input wire logic discharge_short_latch_fail_fault_i,
    input wire logic imbalance_active_fail_fault_i,
    input wire logic imbalance_rest_fail_fault_i,
    input wire logic second_level_protector_fail_fault_i,
    input wire logic discharge_switch_fail_fault_i,
    input wire logic charge_switch_fail_fault_i,
    output logic any_alert_o,
    output logic any_fault_o
);
    import pfsb_pkg::*;

    typedef struct packed {
        logic [7:0] safety_enable;
        logic [7:0] permanent_enable_first;
        logic [7:0] permanent_enable_second;
        logic any_alert;
        logic any_fault;
    } pfsb_top_state_type;

    pfsb_top_state_type state;
    pfsb_top_state_type next_state;

    pfsb_reg_if rbus ();

    logic [7:0] safety_alert_third_cond;
    logic [7:0] safety_alert_third_en;
    logic [7:0] safety_fault_third_cond;
    logic [7:0] permanent_alert_first_cond;
    logic [7:0] permanent_fault_first_cond;
    logic [7:0] permanent_alert_second_cond;
    logic [7:0] permanent_fault_second_cond;

    logic [7:0] safety_alert_third;
    logic [7:0] safety_fault_third;
    logic [7:0] permanent_alert_first;
    logic [7:0] permanent_fault_first;
    logic [7:0] permanent_alert_second;
    logic [7:0] permanent_fault_second;
    logic [7:0] alert_suspend_mask;

    // Gather the detector levels into their byte positions
    always_comb begin
        safety_alert_third_cond = 8'h00;
        safety_alert_third_cond[BIT_DISCHARGE_OVERCURRENT_TIER3] =
            discharge_overcurrent_tier3_alert_i; // (R2)
        safety_alert_third_cond[BIT_DISCHARGE_SHORT_LATCH] =
            discharge_short_latch_alert_i; // (R3)
        safety_alert_third_cond[BIT_DISCHARGE_OVERCURRENT_LATCH] =
            discharge_overcurrent_latch_alert_i; // (R3)
        safety_alert_third_cond[BIT_CELL_OVERVOLTAGE_LATCH] =
            cell_overvoltage_latch_alert_i; // (R3)
        safety_alert_third_cond[BIT_PRECHARGE_TIMEOUT_SUSPEND] =
            precharge_timeout_suspend_i; // (R4)

        // Suspension is a state, shown whatever the enables say
        safety_alert_third_en = state.safety_enable;
        safety_alert_third_en[BIT_PRECHARGE_TIMEOUT_SUSPEND] = 1'b1; // (R4)

        safety_fault_third_cond = 8'h00;
        safety_fault_third_cond[BIT_DISCHARGE_OVERCURRENT_TIER3] =
            discharge_overcurrent_tier3_fault_i; // (R5)
        safety_fault_third_cond[BIT_DISCHARGE_SHORT_LATCH] =
            discharge_short_latch_fault_i; // (R5)
        safety_fault_third_cond[BIT_DISCHARGE_OVERCURRENT_LATCH] =
            discharge_overcurrent_latch_fault_i; // (R5)
        safety_fault_third_cond[BIT_CELL_OVERVOLTAGE_LATCH] =
            cell_overvoltage_latch_fault_i; // (R5)
        safety_fault_third_cond[BIT_PRECHARGE_TIMEOUT_FAULT] =
            precharge_timeout_fault_i; // (R5)
        safety_fault_third_cond[BIT_HOST_WATCHDOG_FAULT] =
            host_watchdog_fault_i; // (R5)

        permanent_alert_first_cond = 8'h00;
        permanent_alert_first_cond[BIT_COPPER_DEPOSITION_FAIL] =
            copper_deposition_fail_alert_i; // (R7)
        permanent_alert_first_cond[BIT_SAFETY_FET_OVERTEMP_FAIL] =
            safety_fet_overtemp_fail_alert_i; // (R7)
        permanent_alert_first_cond[BIT_SAFETY_OVERTEMP_FAIL] =
            safety_overtemp_fail_alert_i; // (R7)
        permanent_alert_first_cond[BIT_SAFETY_DISCHARGE_OVERCURRENT_FAIL] =
            safety_discharge_overcurrent_fail_alert_i; // (R8)
        permanent_alert_first_cond[BIT_SAFETY_CHARGE_OVERCURRENT_FAIL] =
            safety_charge_overcurrent_fail_alert_i; // (R8)
        permanent_alert_first_cond[BIT_SAFETY_CELL_OVERVOLTAGE_FAIL] =
            safety_cell_overvoltage_fail_alert_i; // (R8)
        permanent_alert_first_cond[BIT_SAFETY_CELL_UNDERVOLTAGE_FAIL] =
            safety_cell_undervoltage_fail_alert_i; // (R8)

        permanent_fault_first_cond = 8'h00;
        permanent_fault_first_cond[BIT_COPPER_DEPOSITION_FAIL] =
            copper_deposition_fail_fault_i; // (R7)
        permanent_fault_first_cond[BIT_SAFETY_FET_OVERTEMP_FAIL] =
            safety_fet_overtemp_fail_fault_i; // (R7)
        permanent_fault_first_cond[BIT_SAFETY_OVERTEMP_FAIL] =
            safety_overtemp_fail_fault_i; // (R7)
        permanent_fault_first_cond[BIT_SAFETY_DISCHARGE_OVERCURRENT_FAIL] =
            safety_discharge_overcurrent_fail_fault_i; // (R8)
        permanent_fault_first_cond[BIT_SAFETY_CHARGE_OVERCURRENT_FAIL] =
            safety_charge_overcurrent_fail_fault_i; // (R8)
        permanent_fault_first_cond[BIT_SAFETY_CELL_OVERVOLTAGE_FAIL] =
            safety_cell_overvoltage_fail_fault_i; // (R8)
        permanent_fault_first_cond[BIT_SAFETY_CELL_UNDERVOLTAGE_FAIL] =
            safety_cell_undervoltage_fail_fault_i; // (R8)

        permanent_alert_second_cond = 8'h00;
        permanent_alert_second_cond[BIT_DISCHARGE_SHORT_LATCH_FAIL] =
            discharge_short_latch_fail_alert_i; // (R9)
        permanent_alert_second_cond[BIT_IMBALANCE_ACTIVE_FAIL] =
            imbalance_active_fail_alert_i; // (R9)
        permanent_alert_second_cond[BIT_IMBALANCE_REST_FAIL] =
            imbalance_rest_fail_alert_i; // (R9)
        permanent_alert_second_cond[BIT_SECOND_LEVEL_PROTECTOR_FAIL] =
            second_level_protector_fail_alert_i; // (R10)
        permanent_alert_second_cond[BIT_DISCHARGE_SWITCH_FAIL] =
            discharge_switch_fail_alert_i; // (R10)
        permanent_alert_second_cond[BIT_CHARGE_SWITCH_FAIL] =
            charge_switch_fail_alert_i; // (R10)

        permanent_fault_second_cond = 8'h00;
        permanent_fault_second_cond[BIT_DISCHARGE_SHORT_LATCH_FAIL] =
            discharge_short_latch_fail_fault_i; // (R9)
        permanent_fault_second_cond[BIT_IMBALANCE_ACTIVE_FAIL] =
            imbalance_active_fail_fault_i; // (R9)
        permanent_fault_second_cond[BIT_IMBALANCE_REST_FAIL] =
            imbalance_rest_fail_fault_i; // (R9)
        permanent_fault_second_cond[BIT_SECOND_LEVEL_PROTECTOR_FAIL] =
            second_level_protector_fail_fault_i; // (R10)
        permanent_fault_second_cond[BIT_DISCHARGE_SWITCH_FAIL] =
            discharge_switch_fail_fault_i; // (R10)
        permanent_fault_second_cond[BIT_CHARGE_SWITCH_FAIL] =
            charge_switch_fail_fault_i; // (R10)
    end

    pfsb_flag_byte #(
        .RESERVED_MASK(RSVD_SAFETY_ALERT_THIRD)
    ) u_safety_alert_third (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(safety_alert_third_cond),
        .en_i(safety_alert_third_en), // (R1)
        .flags_o(safety_alert_third)
    );

    pfsb_flag_byte #(
        .RESERVED_MASK(RSVD_SAFETY_FAULT_THIRD)
    ) u_safety_fault_third (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(safety_fault_third_cond),
        .en_i(state.safety_enable),
        .flags_o(safety_fault_third)
    );

    pfsb_flag_byte #(
        .RESERVED_MASK(RSVD_PERMANENT_FIRST)
    ) u_permanent_alert_first (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(permanent_alert_first_cond),
        .en_i(state.permanent_enable_first), // (R6)
        .flags_o(permanent_alert_first)
    );

    pfsb_flag_byte #(
        .RESERVED_MASK(RSVD_PERMANENT_FIRST)
    ) u_permanent_fault_first (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(permanent_fault_first_cond),
        .en_i(state.permanent_enable_first),
        .flags_o(permanent_fault_first)
    );

    pfsb_flag_byte #(
        .RESERVED_MASK(RSVD_PERMANENT_SECOND)
    ) u_permanent_alert_second (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(permanent_alert_second_cond),
        .en_i(state.permanent_enable_second), // (R6)
        .flags_o(permanent_alert_second)
    );

    pfsb_flag_byte #(
        .RESERVED_MASK(RSVD_PERMANENT_SECOND)
    ) u_permanent_fault_second (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(permanent_fault_second_cond),
        .en_i(state.permanent_enable_second),
        .flags_o(permanent_fault_second)
    );

    pfsb_wb_slave u_wb_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .ack_o(ack_o),
        .dat_o(dat_o),
        .rbus(rbus.bus)
    );

    // Read decode; unmapped words read zero
    always_comb begin
        if (rbus.addr == OFF_SAFETY_ALERT_THIRD) begin
            rbus.rdata = safety_alert_third;
        end else if (rbus.addr == OFF_SAFETY_FAULT_THIRD) begin
            rbus.rdata = safety_fault_third;
        end else if (rbus.addr == OFF_PERMANENT_ALERT_FIRST) begin
            rbus.rdata = permanent_alert_first;
        end else if (rbus.addr == OFF_PERMANENT_FAULT_FIRST) begin
            rbus.rdata = permanent_fault_first;
        end else if (rbus.addr == OFF_PERMANENT_ALERT_SECOND) begin
            rbus.rdata = permanent_alert_second;
        end else if (rbus.addr == OFF_PERMANENT_FAULT_SECOND) begin
            rbus.rdata = permanent_fault_second;
        end else if (rbus.addr == OFF_SAFETY_ENABLE) begin
            rbus.rdata = state.safety_enable;
        end else if (rbus.addr == OFF_PERMANENT_ENABLE_FIRST) begin
            rbus.rdata = state.permanent_enable_first;
        end else if (rbus.addr == OFF_PERMANENT_ENABLE_SECOND) begin
            rbus.rdata = state.permanent_enable_second;
        end else begin
            rbus.rdata = 8'h00;
        end
    end

    // The suspend bit is not an alert and stays out of the summary
    assign alert_suspend_mask = 8'h01 << BIT_PRECHARGE_TIMEOUT_SUSPEND;

    always_comb begin
        next_state = state;
        // Enable writes; status bytes ignore writes
        if (rbus.wr_stb && rbus.addr == OFF_SAFETY_ENABLE) begin
            next_state.safety_enable = rbus.wdata & MASK_SAFETY_ENABLE;
        end else if (rbus.wr_stb && rbus.addr == OFF_PERMANENT_ENABLE_FIRST) begin
            next_state.permanent_enable_first =
                rbus.wdata & ~RSVD_PERMANENT_FIRST; // (R13)
        end else if (rbus.wr_stb &&
                     rbus.addr == OFF_PERMANENT_ENABLE_SECOND) begin
            next_state.permanent_enable_second =
                rbus.wdata & ~RSVD_PERMANENT_SECOND; // (R13)
        end
        next_state.any_alert = |(safety_alert_third & ~alert_suspend_mask) |
                               |permanent_alert_first |
                               |permanent_alert_second;
        next_state.any_fault = |safety_fault_third |
                               |permanent_fault_first |
                               |permanent_fault_second;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '{safety_enable: RESET_SAFETY_ENABLE,
                       permanent_enable_first: RESET_PERMANENT_ENABLE_FIRST,
                       permanent_enable_second: RESET_PERMANENT_ENABLE_SECOND,
                       any_alert: 1'b0,
                       any_fault: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign any_alert_o = state.any_alert;
    assign any_fault_o = state.any_fault;
endmodule

//--- verilog/pfsb_wb_slave.sv
// Classic Wishbone slave that answers every access one cycle after request
`timescale 1ns/1ns
module pfsb_wb_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    pfsb_reg_if.bus rbus
);
    import pfsb_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pfsb_slave_state_type;

    pfsb_slave_state_type state;
    pfsb_slave_state_type next_state;
    logic take;

    assign take = cyc_i & stb_i & ~state.ack;
    assign rbus.addr = {adr_i[7:2], 2'b00};
    assign rbus.wdata = dat_i[7:0];
    // Only the low lane carries register data
    assign rbus.wr_stb = take & we_i & sel_i[0];

    always_comb begin
        next_state = state;
        next_state.ack = take;
        if (take && !we_i) begin
            next_state.dat = {24'h000000, rbus.rdata};
        end else if (take) begin
            next_state.dat = RESET_DATA;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '{ack: 1'b0, dat: RESET_DATA};
        end else begin
            state <= next_state;
        end
    end

    assign ack_o = state.ack;
    assign dat_o = state.dat;
endmodule
